/* File: hdl/boot_pkg.sv */
// Shared constants and types of the boot message loader
package boot_pkg;
   localparam int CLK_NS = 20;
   localparam int DLY_UNIT_NS = 1000;
   localparam int DLY_UNIT_CYC = (DLY_UNIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int STRAP_CYC = 8;
   localparam logic [7:0] MSG_END = 8'h00;
   localparam logic [7:0] MSG_WRITE = 8'h01;
   localparam logic [7:0] MSG_DELAY = 8'h02;
   localparam logic [7:0] MSG_NOP = 8'h03;
   localparam logic [7:0] MSG_MULTI_WB = 8'h04;
   localparam logic [7:0] MSG_FALL_WB = 8'h05;
   localparam logic [7:0] MSG_END_WAIT = 8'h06;
   localparam logic [7:0] EE_WR_ADDR = 8'ha0;
   localparam logic [7:0] EE_RD_ADDR = 8'ha1;
   localparam logic [15:0] EE_BOOT_START = 16'h0000;
   localparam logic [15:0] EE_WB_START = 16'h0020;
   localparam logic [15:0] IFREG_BASE = 16'h0800;
   localparam logic [15:0] CORE_CTRL_ADDR = 16'h081c;
   localparam int CTRL_IFWR_BIT = 6;
   localparam int IFREG_NUM = 8;
   localparam int WB_BYTES = 35;
   localparam logic [5:0] SETUP_LAST = 6'h05;
   localparam logic [5:0] WB_DATA0 = 6'h04;
   localparam logic [5:0] WB_LAST = 6'(WB_BYTES + 1);
   localparam logic [2:0] SCL_HIGH_PH = 3'h5;
   localparam logic [2:0] SE_SCL_PH = 3'h2;
   localparam logic [2:0] START_SDA_PH = 3'h4;
   localparam logic [2:0] STOP_SDA_PH = 3'h5;
   localparam logic [2:0] SAMPLE_PH = 3'h7;
   typedef enum logic [2:0] {
      OP_START = 3'h0,
      OP_STOP = 3'h1,
      OP_WRITE = 3'h3,
      OP_READ_ACK = 3'h2,
      OP_READ_NACK = 3'h6
   } op_e;
endpackage

/* File: hdl/ee_link_if.sv */
// Toggle handshake between the loader and the serial byte engine
`timescale 1ns/1ps
`default_nettype none
interface ee_link_if;
   logic req_tgl;
   boot_pkg::op_e op;
   logic [7:0] tx;
   logic done_tgl;
   logic [7:0] rx;
   logic nack;
   modport ctrl(output req_tgl, output op, output tx, input done_tgl, input rx, input nack);
   modport engine(input req_tgl, input op, input tx, output done_tgl, output rx, output nack);
endinterface
`default_nettype wire

/* File: hdl/sync3.sv */
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   wire logic [W-1:0] agree = ~(s2_r ^ s3_r);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q <= (agree & s3_r) | (~agree & q);
      end
   end
endmodule
`default_nettype wire

/* File: hdl/ee_byte_engine.sv */
// Serial bus byte engine on the link clock, eight phases per bit
`timescale 1ns/1ps
`default_nettype none
module ee_byte_engine (
   input wire logic link_clk,
   input wire logic nrst,
   ee_link_if.engine lnk,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe,
   output logic sda_o,
   output logic sda_oe
);
   logic [1:0] in_s;
   logic busy_r, seen_r, done_r, nack_r;
   logic [2:0] ph_r;
   logic [3:0] bits_r;
   logic [8:0] sh_r;
   logic [7:0] rx_r;
   boot_pkg::op_e op_r;
   wire logic req_s = in_s[0];
   wire logic sda_s = in_s[1];
   wire logic is_start = op_r == boot_pkg::OP_START;
   wire logic is_stop = op_r == boot_pkg::OP_STOP;
   wire logic new_se = lnk.op == boot_pkg::OP_START || lnk.op == boot_pkg::OP_STOP;
   wire logic [8:0] sh_in = {sh_r[7:0], sda_s};
   // Data bits keep SCL high for phases 5..7, three of eight
   wire logic scl_lvl = (is_start || is_stop) ? (ph_r >= boot_pkg::SE_SCL_PH) :
                        (ph_r >= boot_pkg::SCL_HIGH_PH);
   wire logic sda_lvl = is_start ? (ph_r < boot_pkg::START_SDA_PH) :
                        is_stop ? (ph_r >= boot_pkg::STOP_SDA_PH) : sh_r[8];

   sync3 #(.W(2)) u_sync (
      .clk(link_clk),
      .nrst(nrst),
      .d({sda_i, lnk.req_tgl}),
      .q(in_s)
   );

   assign lnk.done_tgl = done_r;
   assign lnk.rx = rx_r;
   assign lnk.nack = nack_r;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         busy_r <= 1'b0;
         seen_r <= 1'b0;
         done_r <= 1'b0;
         nack_r <= 1'b0;
         rx_r <= 8'h00;
         ph_r <= 3'h0;
         bits_r <= 4'h0;
         sh_r <= 9'h000;
         op_r <= boot_pkg::OP_STOP;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else if (!busy_r) begin
         if (req_s != seen_r) begin
            seen_r <= req_s;
            busy_r <= 1'b1;
            op_r <= lnk.op;
            ph_r <= 3'h0;
            bits_r <= new_se ? 4'h1 : 4'h9;
            // Ack slot released on writes and refused reads, driven low by us on acked reads
            sh_r <= (lnk.op == boot_pkg::OP_WRITE) ? {lnk.tx, 1'b1} :
                    {8'hff, lnk.op == boot_pkg::OP_READ_NACK};
         end
      end else begin
         ph_r <= ph_r + 3'h1;
         scl_oe <= ~scl_lvl; // RQ22
         // SDA never moves in the phase where SCL falls
         if (ph_r != 3'h0) begin
            sda_oe <= ~sda_lvl; // RQ2
         end
         if (ph_r == boot_pkg::SAMPLE_PH) begin
            sh_r <= sh_in;
            bits_r <= bits_r - 4'h1;
            if (bits_r == 4'h1) begin
               busy_r <= 1'b0;
               rx_r <= sh_in[8:1];
               nack_r <= sh_in[0];
               done_r <= ~done_r;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: hdl/boot_loader.sv */
// Self-boot message loader and interface register writeback engine
// What this block does
// RQ1 - Reads the memory stream as messages, each led by a type byte
// RQ2 - Multi-byte fields are most significant first
// RQ3 - Write message: two length bytes, then that many body bytes to the target
// RQ4 - Write body holds zero chip byte, two address bytes, then data
// RQ5 - No-op is a lone type byte, skipped
// RQ6 - End-and-wait stops parsing but stays armed for writeback
// RQ7 - Rising trigger edge starts writeback; falling edge once configured so
// RQ8 - One writeback per boot unless multiple writeback was configured
// RQ9 - Write-protect pin is pulled low during writeback
// RQ10 - Writeback copies only the interface registers
// RQ11 - Stream writes interface registers only with control bit 6 set
// RQ12 - Writeback data goes to memory bytes 32 to 63
// RQ13 - Image holds six-byte write header at byte 26
// RQ14 - Image enables interface register writes first, at byte 0
// RQ15 - Control register low byte at 0x1c carries enable value 0x40
// RQ16 - Writeback addresses the memory at 0xa0
// RQ17 - Writeback moves at most 35 bytes
// RQ18 - Writeback takes about 73 us at nominal bus rate
// RQ19 - Boot starts at reset release with select and protect pins high
// RQ20 - No boot while protect pin is low
// RQ21 - Boot stream read as bus master from address 0xa1
// RQ22 - Bus clock at one eighth of link clock, three-eighths high
// RQ23 - Length counts chip byte, address bytes and data
// RQ24 - Delay message pauses for a big-endian count of time units
`timescale 1ns/1ps
`default_nettype none
module boot_loader #(
   parameter int DLY_UNIT_CYC = boot_pkg::DLY_UNIT_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic self_boot_select,
   input wire logic writeback_trigger_pin,
   input wire logic wp_i,
   output logic wp_o,
   output logic wp_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic scl_o,
   output logic scl_oe,
   input wire logic dsp_ifreg_we,
   input wire logic [2:0] dsp_ifreg_idx,
   input wire logic [31:0] dsp_ifreg_wdata,
   input wire logic [2:0] ifreg_rd_idx,
   output logic [31:0] ifreg_rdata,
   output logic [15:0] core_ctrl,
   output logic tgt_we,
   output logic [15:0] tgt_addr,
   output logic [15:0] tgt_offset,
   output logic [7:0] tgt_data,
   output logic boot_busy,
   output logic boot_done,
   output logic boot_err,
   output logic wb_busy,
   output logic wb_armed
);
   typedef enum logic [3:0] {
      S_STRAP = 4'h0,
      S_SETUP = 4'h1,
      S_TYPE = 4'h3,
      S_LENH = 4'h2,
      S_LENL = 4'h6,
      S_BODY = 4'h7,
      S_DLYH = 4'h5,
      S_DLYL = 4'h4,
      S_DELAY = 4'hc,
      S_FIN = 4'hd,
      S_IDLE = 4'hf,
      S_WB = 4'he,
      S_ERR = 4'ha
   } state_e;

   ee_link_if lnk ();

   state_e st_r, st_nxt;
   logic [5:0] seq_r, seq_nxt;
   logic [15:0] len_r, len_nxt;
   logic [15:0] dly_r, dly_nxt;
   logic [31:0] unit_r;
   logic [1:0] pos_r, pos_nxt;
   logic pend_r, req_r, seen_r, wb_prev_r;
   logic [7:0] tx_r;
   logic multi_r, fall_r, wait_r;
   logic [31:0] ifreg_r [boot_pkg::IFREG_NUM];
   logic [2:0] pin_s;
   logic done_s;
   boot_pkg::op_e op_sel;
   logic [7:0] tx_sel;
   logic data_evt;

   wire logic sb_s = pin_s[0];
   wire logic wp_s = pin_s[1];
   wire logic wb_s = pin_s[2];
   wire logic done_evt = pend_r && (done_s != seen_r);
   wire logic need_op = st_r != S_STRAP && st_r != S_DELAY && st_r != S_IDLE;
   wire logic is_wr = op_sel == boot_pkg::OP_WRITE;
   wire logic bad_ack = done_evt && is_wr && lnk.nack;
   wire logic [7:0] rx = lnk.rx;
   wire logic [15:0] len_new = {len_r[15:8], rx};
   wire logic [4:0] wb_idx = 5'(seq_r - boot_pkg::WB_DATA0);
   wire logic [31:0] wb_word = ifreg_r[wb_idx[4:2]];
   wire logic [7:0] wb_byte = 8'(wb_word >> {~wb_idx[1:0], 3'b000}); // RQ2
   wire logic trig = fall_r ? (wb_prev_r & ~wb_s) : (~wb_prev_r & wb_s); // RQ7
   wire logic unit_end = unit_r == 32'(DLY_UNIT_CYC - 1);
   wire logic ifwr_en = core_ctrl[boot_pkg::CTRL_IFWR_BIT]; // RQ11
   wire logic if_hit = tgt_addr[15:3] == boot_pkg::IFREG_BASE[15:3];
   wire logic ctl_hit = tgt_addr == boot_pkg::CORE_CTRL_ADDR;
   wire logic [2:0] bw_idx = 3'(tgt_addr[2:0] + tgt_offset[4:2]);
   wire logic [1:0] bw_lane = ~tgt_offset[1:0];

   sync3 #(.W(3)) u_pins (
      .clk(clk),
      .nrst(nrst),
      .d({writeback_trigger_pin, wp_i, self_boot_select}),
      .q(pin_s)
   );

   sync3 #(.W(1)) u_done (
      .clk(clk),
      .nrst(nrst),
      .d(lnk.done_tgl),
      .q(done_s)
   );

   ee_byte_engine u_eng (
      .link_clk(link_clk),
      .nrst(nrst),
      .lnk(lnk.engine),
      .sda_i(sda_i),
      .scl_o(scl_o),
      .scl_oe(scl_oe),
      .sda_o(sda_o),
      .sda_oe(sda_oe)
   );

   assign lnk.req_tgl = req_r;
   assign lnk.op = op_sel;
   assign lnk.tx = tx_r;

   ////////////////////////////////////////////////////////////////////////////
   // Bus operation for the current step; held steady while pending
   always_comb begin
      op_sel = boot_pkg::OP_READ_ACK;
      tx_sel = 8'h00;
      case (st_r)
         S_SETUP: begin
            op_sel = (seq_r == 6'h0 || seq_r == 6'h4) ? boot_pkg::OP_START :
                     boot_pkg::OP_WRITE;
            case (seq_r)
               6'h1: tx_sel = boot_pkg::EE_WR_ADDR;
               6'h2: tx_sel = boot_pkg::EE_BOOT_START[15:8];
               6'h3: tx_sel = boot_pkg::EE_BOOT_START[7:0];
               6'h5: tx_sel = boot_pkg::EE_RD_ADDR; // RQ21
               default: tx_sel = 8'h00;
            endcase
         end
         S_FIN: begin
            // Last read is refused so the memory frees the data line
            op_sel = (seq_r == 6'h0) ? boot_pkg::OP_READ_NACK : boot_pkg::OP_STOP;
         end
         S_WB: begin
            op_sel = (seq_r == 6'h0) ? boot_pkg::OP_START :
                     (seq_r == boot_pkg::WB_LAST) ? boot_pkg::OP_STOP :
                     boot_pkg::OP_WRITE; // RQ17
            case (seq_r)
               6'h1: tx_sel = boot_pkg::EE_WR_ADDR; // RQ16
               6'h2: tx_sel = boot_pkg::EE_WB_START[15:8]; // RQ12
               6'h3: tx_sel = boot_pkg::EE_WB_START[7:0]; // RQ12
               default: tx_sel = wb_byte; // RQ10
            endcase
         end
         S_ERR: op_sel = boot_pkg::OP_STOP;
         default: op_sel = boot_pkg::OP_READ_ACK;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      seq_nxt = seq_r;
      len_nxt = len_r;
      dly_nxt = dly_r;
      pos_nxt = pos_r;
      data_evt = 1'b0;
      case (st_r)
         S_STRAP: begin
            // Straps judged once the pin synchronisers have settled
            if (unit_r == 32'(boot_pkg::STRAP_CYC)) begin
               st_nxt = (sb_s && wp_s) ? S_SETUP : S_IDLE; // RQ19 RQ20
               seq_nxt = 6'h0;
            end
         end
         S_SETUP: begin
            if (bad_ack) begin
               st_nxt = S_ERR;
            end else if (done_evt) begin
               seq_nxt = seq_r + 6'h1;
               if (seq_r == boot_pkg::SETUP_LAST) st_nxt = S_TYPE;
            end
         end
         S_TYPE: begin
            if (done_evt) begin
               seq_nxt = 6'h0;
               case (rx) // RQ1
                  boot_pkg::MSG_WRITE: st_nxt = S_LENH; // RQ3
                  boot_pkg::MSG_DELAY: st_nxt = S_DLYH; // RQ24
                  boot_pkg::MSG_NOP: st_nxt = S_TYPE; // RQ5
                  boot_pkg::MSG_MULTI_WB: st_nxt = S_TYPE;
                  boot_pkg::MSG_FALL_WB: st_nxt = S_TYPE;
                  default: st_nxt = S_FIN;
               endcase
            end
         end
         S_LENH: begin
            if (done_evt) begin
               len_nxt = {rx, len_r[7:0]}; // RQ2
               st_nxt = S_LENL;
            end
         end
         S_LENL: begin
            if (done_evt) begin
               len_nxt = len_new; // RQ23
               pos_nxt = 2'h0;
               st_nxt = (len_new == 16'h0) ? S_TYPE : S_BODY;
            end
         end
         S_BODY: begin
            if (done_evt) begin
               len_nxt = len_r - 16'h1; // RQ3
               if (pos_r != 2'h3) pos_nxt = pos_r + 2'h1;
               data_evt = pos_r == 2'h3;
               if (len_r == 16'h1) st_nxt = S_TYPE;
            end
         end
         S_DLYH: begin
            if (done_evt) begin
               dly_nxt = {rx, dly_r[7:0]};
               st_nxt = S_DLYL;
            end
         end
         S_DLYL: begin
            if (done_evt) begin
               dly_nxt = {dly_r[15:8], rx}; // RQ24
               st_nxt = S_DELAY;
            end
         end
         S_DELAY: begin
            // Bus stays parked mid-read; the memory just waits for SCL
            if (dly_r == 16'h0) begin
               st_nxt = S_TYPE;
            end else if (unit_end) begin
               dly_nxt = dly_r - 16'h1; // RQ24
            end
         end
         S_FIN: begin
            if (done_evt) begin
               seq_nxt = seq_r + 6'h1;
               if (seq_r != 6'h0) st_nxt = S_IDLE;
            end
         end
         S_IDLE: begin
            if (wb_armed && trig) begin
               st_nxt = S_WB; // RQ7
               seq_nxt = 6'h0;
            end
         end
         S_WB: begin
            if (bad_ack) begin
               st_nxt = S_ERR;
            end else if (done_evt) begin
               seq_nxt = seq_r + 6'h1;
               if (seq_r == boot_pkg::WB_LAST) st_nxt = S_IDLE; // RQ18
            end
         end
         S_ERR: begin
            if (done_evt) st_nxt = S_IDLE;
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= S_STRAP;
         seq_r <= 6'h0;
         len_r <= 16'h0;
         dly_r <= 16'h0;
         pos_r <= 2'h0;
      end else begin
         st_r <= st_nxt;
         seq_r <= seq_nxt;
         len_r <= len_nxt;
         dly_r <= dly_nxt;
         pos_r <= pos_nxt;
      end
   end

   // Request toggles; the engine acts on a change, not on a level
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend_r <= 1'b0;
         req_r <= 1'b0;
         tx_r <= 8'h00;
         seen_r <= 1'b0;
      end else if (done_evt) begin
         pend_r <= 1'b0;
         seen_r <= done_s;
      end else if (!pend_r && need_op) begin
         pend_r <= 1'b1;
         req_r <= ~req_r;
         // Captured with the toggle so a program write cannot tear it
         tx_r <= tx_sel;
      end
   end

   // Strap wait and delay unit share one counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         unit_r <= 32'h0;
      end else if (st_r == S_STRAP || (st_r == S_DELAY && !unit_end)) begin
         unit_r <= unit_r + 32'h1;
      end else begin
         unit_r <= 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Options and status
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         multi_r <= 1'b0;
         fall_r <= 1'b0;
         wait_r <= 1'b0;
         wb_armed <= 1'b0;
         wb_prev_r <= 1'b0;
         boot_busy <= 1'b0;
         boot_done <= 1'b0;
         boot_err <= 1'b0;
         wb_busy <= 1'b0;
         wp_o <= 1'b0;
         wp_oe <= 1'b0;
      end else begin
         wb_prev_r <= wb_s;
         if (st_r == S_TYPE && done_evt) begin
            if (rx == boot_pkg::MSG_MULTI_WB) multi_r <= 1'b1; // RQ8
            if (rx == boot_pkg::MSG_FALL_WB) fall_r <= 1'b1; // RQ7
            if (rx == boot_pkg::MSG_END_WAIT) wait_r <= 1'b1; // RQ6
         end
         boot_busy <= st_nxt != S_STRAP && st_nxt != S_IDLE && st_nxt != S_WB &&
                      !(st_nxt == S_ERR && wb_busy);
         if (st_r == S_FIN && st_nxt == S_IDLE) begin
            boot_done <= 1'b1;
            wb_armed <= wait_r; // RQ6
         end
         if (st_r == S_TYPE && st_nxt == S_FIN && rx != boot_pkg::MSG_END &&
             rx != boot_pkg::MSG_END_WAIT) begin
            boot_err <= 1'b1;
         end
         if (st_nxt == S_ERR) boot_err <= 1'b1;
         if (st_r == S_IDLE && st_nxt == S_WB) begin
            wb_busy <= 1'b1;
            wb_armed <= multi_r; // RQ8
            wp_oe <= 1'b1; // RQ9
         end else if (wb_busy && st_nxt == S_IDLE) begin
            wb_busy <= 1'b0;
            wp_oe <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Body bytes out to the target, plus local register images
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tgt_we <= 1'b0;
         tgt_addr <= 16'h0;
         tgt_offset <= 16'h0;
         tgt_data <= 8'h00;
      end else begin
         tgt_we <= data_evt; // RQ4
         if (st_r == S_LENL) tgt_offset <= 16'h0;
         if (st_r == S_BODY && done_evt) begin
            if (pos_r == 2'h1) tgt_addr[15:8] <= rx; // RQ4
            if (pos_r == 2'h2) tgt_addr[7:0] <= rx; // RQ4
            if (pos_r == 2'h3) tgt_data <= rx;
         end
         if (tgt_we) tgt_offset <= tgt_offset + 16'h1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_ctrl <= 16'h0;
         ifreg_rdata <= 32'h0;
         for (int i = 0; i < boot_pkg::IFREG_NUM; i++) ifreg_r[i] <= 32'h0;
      end else begin
         ifreg_rdata <= ifreg_r[ifreg_rd_idx];
         if (tgt_we && ctl_hit && tgt_offset[15:1] == 15'h0) begin
            if (tgt_offset[0]) core_ctrl[7:0] <= tgt_data; // RQ15
            else core_ctrl[15:8] <= tgt_data;
         end
         if (dsp_ifreg_we) ifreg_r[dsp_ifreg_idx] <= dsp_ifreg_wdata;
         // Stream byte wins over a program word in the same cycle
         if (tgt_we && if_hit && ifwr_en) begin
            ifreg_r[bw_idx][{bw_lane, 3'b000} +: 8] <= tgt_data; // RQ11
         end
      end
   end
endmodule
`default_nettype wire

/* File: verif/boot_loader_monitor.sv */
// Concurrent checks on the boot loader pins and status
`timescale 1ns/1ps
`default_nettype none
module boot_loader_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic self_boot_select,
   input wire logic wp_i,
   input wire logic wp_oe,
   input wire logic scl_oe,
   input wire logic [15:0] core_ctrl,
   input wire logic tgt_we,
   input wire logic [15:0] tgt_addr,
   input wire logic boot_busy,
   input wire logic boot_done,
   input wire logic wb_busy,
   input wire logic wb_armed
);
   logic [15:0] wb_cnt_r;
   // Bounds a writeback; sized for the 80 ns bench link clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) wb_cnt_r <= 16'h0;
      else wb_cnt_r <= wb_busy ? wb_cnt_r + 16'h1 : 16'h0;
   end
   ////////////////////////////////////////////////////////////////
   chk_wp_rise: assert property (@(posedge clk) disable iff (!nrst)
      $rose(wb_busy) |-> ##[0:1] wp_oe) else $error("protect pin not pulled");
   chk_wp_off: assert property (@(posedge clk) disable iff (!nrst)
      $fell(wb_busy) |-> ##[0:2] !wp_oe) else $error("protect pin held");
   chk_boot_pins: assert property (@(posedge clk) disable iff (!nrst)
      $rose(boot_busy) |-> wp_i && self_boot_select) else $error("boot without pins");
   chk_scl_high: assert property (@(posedge link_clk) disable iff (!nrst)
      $fell(scl_oe) |-> !scl_oe [*3]) else $error("bus clock high too short");
   chk_tgt_pulse: assert property (@(posedge clk) disable iff (!nrst)
      tgt_we |-> boot_busy ##1 !tgt_we) else $error("target strobe bad");
   chk_wb_excl: assert property (@(posedge clk) disable iff (!nrst)
      wb_busy |-> !boot_busy && boot_done) else $error("writeback during boot");
   chk_armed_done: assert property (@(posedge clk) disable iff (!nrst)
      wb_armed |-> boot_done && !boot_busy) else $error("armed before end");
   chk_ctrl_src: assert property (@(posedge clk) disable iff (!nrst)
      $changed(core_ctrl) |-> tgt_addr == 16'h081c) else $error("control reg stray write");
   chk_wb_time: assert property (@(posedge clk) disable iff (!nrst)
      wb_busy |-> wb_cnt_r < 16'd14000) else $error("writeback too long");
endmodule
bind boot_loader boot_loader_monitor boot_loader_monitor_i (.clk, .nrst, .link_clk,
   .self_boot_select, .wp_i, .wp_oe, .scl_oe, .core_ctrl, .tgt_we, .tgt_addr,
   .boot_busy, .boot_done, .wb_busy, .wb_armed);
`default_nettype wire

/* File: verif/ee_model.sv */
// Behavioural serial memory answering the loader on the bus
`timescale 1ns/1ps
`default_nettype none
module ee_model (
   input wire logic scl,
   input wire logic sda,
   output logic sda_low
);
   logic [7:0] mem [128];
   logic [7:0] sh;
   logic [6:0] ptr;
   logic [7:0] ad;
   logic rd = 0;
   int bitn = 8;
   int st = 0;
   initial begin
      sda_low = 0;
      foreach (mem[i]) mem[i] = 8'hff;
   end
   // Start restarts byte framing
   always @(negedge sda) if (scl === 1'b1) begin
      bitn = 8;
      st = 0;
      rd = 0;
   end
   always @(posedge scl) begin
      if (bitn < 8) sh = {sh[6:0], sda};
      else if (rd && sda) rd = 0;
   end
   always @(negedge scl) begin
      bitn = (bitn == 8) ? 0 : bitn + 1;
      sda_low = 0;
      if (rd && bitn == 8) ptr++;
      if (bitn == 8 && !rd) begin
         sda_low = 1;
         if (st == 0) ad = sh;
         if (st == 0) rd = sh[0];
         else if (st == 2) ptr = sh[6:0];
         else if (st > 2) begin
            mem[ptr] = sh;
            ptr++;
         end
         st++;
      end
      if (rd && bitn < 8) sda_low = !mem[ptr][7 - bitn];
   end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Bench for the boot loader against a serial memory model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 0, link_clk = 0, nrst = 0, sel = 1, trig = 0, wpp = 1, dwe = 0;
   logic [2:0] didx = 0, ridx = 0;
   logic [31:0] dwd = 0, rd;
   logic [31:0] ifw [8];
   logic wp_o, wp_oe, sda_o, sda_oe, scl_o, scl_oe, ee_low, twe, bbusy, bdone, berr;
   logic wbusy, armed;
   logic [15:0] cc, taddr, toff;
   logic [7:0] tdat, b;
   logic [39:0] expq [$];
   int mismatches = 0, samples_checked = 0, n, wa = 0;
   wire scl = !scl_oe;
   wire sda = !(sda_oe || ee_low);
   always #10 clk = !clk;
   initial begin
      #7;
      forever #40 link_clk = !link_clk;
   end
   boot_loader #(.DLY_UNIT_CYC(2)) boot_loader_i (.clk, .nrst, .link_clk,
      .self_boot_select(sel), .writeback_trigger_pin(trig), .wp_i(wp_oe ? 1'b0 : wpp),
      .wp_o, .wp_oe, .sda_i(sda), .sda_o, .sda_oe, .scl_o, .scl_oe, .dsp_ifreg_we(dwe),
      .dsp_ifreg_idx(didx), .dsp_ifreg_wdata(dwd), .ifreg_rd_idx(ridx), .ifreg_rdata(rd),
      .core_ctrl(cc), .tgt_we(twe), .tgt_addr(taddr), .tgt_offset(toff), .tgt_data(tdat),
      .boot_busy(bbusy), .boot_done(bdone), .boot_err(berr), .wb_busy(wbusy),
      .wb_armed(armed));
   ee_model ee_model_i (.scl, .sda, .sda_low(ee_low));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic test_done;
      if (mismatches == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic put(input logic [63:0] v, input int k);
      for (int i = k - 1; i >= 0; i--) begin
         ee_model_i.mem[wa] = v[i*8 +: 8];
         wa++;
      end
   endtask
   task automatic wait_lvl(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 60000) begin
         @(negedge clk);
         n++;
      end
      if (n == 60000) begin
         chk("timeout", 40'h0, 40'h1);
         test_done();
      end
   endtask
   always @(negedge clk) if (twe === 1'b1) chk("tgt", expq.pop_front(), {taddr, toff, tdat});
   ////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(50));
      @(negedge clk);
      put(64'h01000500081c0040, 8);
      expq.push_back({16'h081c, 16'h0, 8'h00});
      expq.push_back({16'h081c, 16'h1, 8'h40});
      for (int i = 0; i < 18; i++) put(64'h03, 1);
      put(64'h010023000800, 6);
      for (int i = 0; i < 32; i++) begin
         b = 8'($urandom);
         put({56'h0, b}, 1);
         expq.push_back({16'h0800, 16'(i), b});
         ifw[i / 4][31 - 8 * (i % 4) -: 8] = b;
      end
      put(64'h0200030406, 5);
      repeat (5) @(negedge clk);
      nrst = 1;
      wait_lvl(bdone, 1'b1);
      @(negedge clk);
      chk("queue", 40'h0, 40'(expq.size()));
      chk("ctrl", 40'h0040, 40'(cc));
      chk("armed", 40'h1, 40'(armed));
      chk("err", 40'h0, 40'(berr));
      chk("rdad", 40'ha1, 40'(ee_model_i.ad));
      chk("drv", 40'h0, 40'({wp_o, sda_o, scl_o}));
      for (int k = 0; k < 8; k++) begin
         ridx = 3'(k);
         @(negedge clk);
         chk("ifreg", 40'(ifw[k]), 40'(rd));
      end
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 8; k++) begin
            ifw[k] = $urandom;
            didx = 3'(k);
            dwd = ifw[k];
            dwe = 1;
            @(negedge clk);
         end
         dwe = 0;
         trig = 1;
         wait_lvl(wbusy, 1'b1);
         @(negedge clk);
         chk("wp", 40'h1, 40'(wp_oe));
         wait_lvl(wbusy, 1'b0);
         trig = 0;
         for (int i = 0; i < 32; i++)
            chk("wb", 40'(ifw[i / 4][31 - 8 * (i % 4) -: 8]), 40'(ee_model_i.mem[32 + i]));
         chk("hdr", 40'h01, 40'(ee_model_i.mem[26]));
         chk("wr", {8'ha0, 32'd35}, {ee_model_i.ad, 32'(ee_model_i.st)});
         repeat (20) @(negedge clk);
         chk("fall", 40'h0, 40'(wbusy));
         chk("rearm", 40'h1, 40'(armed));
      end
      wpp = 0;
      nrst = 0;
      wa = 0;
      put(64'h0100040008005a05, 8);
      put(64'h06, 1);
      expq.push_back({16'h0800, 16'h0, 8'h5a});
      repeat (6) @(negedge clk);
      nrst = 1;
      repeat (40) @(negedge clk);
      chk("noboot", 40'h0, 40'(bbusy | bdone | armed));
      wpp = 1;
      nrst = 0;
      repeat (6) @(negedge clk);
      nrst = 1;
      wait_lvl(bdone, 1'b1);
      ridx = 3'h0;
      trig = 1;
      repeat (20) @(negedge clk);
      chk("rise", 40'h0, 40'({wbusy, rd}));
      trig = 0;
      wait_lvl(wbusy, 1'b1);
      wait_lvl(wbusy, 1'b0);
      chk("once", 40'h0, 40'({armed, ee_model_i.mem[32]}));
      test_done();
   end
endmodule
`default_nettype wire
